// ---- logic/tmx_defs.svh ----
`ifndef TMX_DEFS_SVH
`define TMX_DEFS_SVH

// register offsets (byte addresses: printed offsets are not all multiples of four)
`define TMX_IDX_TCTL      8'h88
`define TMX_IDX_TMODE     8'h89
`define TMX_IDX_T0LO      8'hC0
`define TMX_IDX_T0HI      8'hC1
`define TMX_IDX_T1LO      8'hC2
`define TMX_IDX_T1HI      8'hC3
`define TMX_IDX_VEC       8'hC4
`define TMX_ADDR_W        10

// timer control bit positions
`define TMX_TC_TF1        7
`define TMX_TC_TR1        6
`define TMX_TC_TF0        5
`define TMX_TC_TR0        4
`define TMX_TC_IE1        3
`define TMX_TC_IT1        2
`define TMX_TC_IE0        1
`define TMX_TC_IT0        0

// vector acknowledge bit positions
`define TMX_VEC_T0        0
`define TMX_VEC_T1        1
`define TMX_VEC_X0        2
`define TMX_VEC_X1        3

// reset values
`define TMX_TCTL_RST      8'h00
`define TMX_TMODE_RST     8'h00
`define TMX_PRESCALE_MSB  4

// internal clock divide: one count per machine cycle of this many clocks
`define TMX_TICK_DIV      4'hC

`endif

// ---- logic/tmx_pkg.sv ----
package tmx_pkg;

   typedef enum logic [1:0] {
      TMX_MODE_13BIT  = 2'h0,
      TMX_MODE_16BIT  = 2'h1,
      TMX_MODE_RELOAD = 2'h2,
      TMX_MODE_SPLIT  = 2'h3
   } tmx_mode_t;

   // one timer's mode nibble
   typedef struct packed {
      logic      gate;
      logic      counter_sel;
      tmx_mode_t mode;
   } tmx_mode_nib_t;

   typedef struct packed {
      logic [7:0] high_count_byte;
      logic [7:0] low_count_byte;
   } tmx_count_t;

   // bus answer state
   typedef enum logic [0:0] {
      TMX_BUS_IDLE = 1'b0,
      TMX_BUS_ACK  = 1'b1
   } tmx_bus_state_t;

endpackage

// ---- logic/tmx_pin_sync.sv ----
`timescale 1ns/1ps
`include "tmx_defs.svh"

// two-stage synchroniser with a falling edge detect on the stable samples
module tmx_pin_sync (
   // clock and reset
   input  wire logic core_clk,
   input  wire logic rst_n,
   // pin
   input  wire logic pin_in,
   // outputs
   output logic      pin_level,
   output logic      pin_fall
);

   logic meta_r;
   logic sync_r;
   logic prev_r;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         meta_r <= 1'b1;
         sync_r <= 1'b1;
         prev_r <= 1'b1;
      end else begin
         meta_r <= pin_in;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign pin_level = sync_r;
   assign pin_fall  = prev_r & ~sync_r;

endmodule

// ---- logic/tmx_timer01.sv ----
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ps
`include "tmx_defs.svh"

// Contract
// - timer 1 overflow sets its flag; vectoring clears it; software may write it.
// - timer 0 overflow sets its flag; vectoring clears it; software may write it.
// - timer 1 counts only while its run bit is set.
// - timer 0 counts only while its run bit is set; in mode 3 its high byte runs on timer 1's run bit.
// - interrupt 1 flag set by edge/level; vector clears in edge mode only.
// - interrupt 0 flag set when edge or level is seen on its pin.
// - interrupt 0 flag cleared by vector only in edge mode; else inverse pin.
// - interrupt 1 type bit set selects falling edge, clear selects low level.
// - interrupt 0 type bit set selects falling edge, clear selects low level.
// - timer 1 gate set requires interrupt 1 pin high plus run bit.
// - timer 0 gate set requires interrupt 0 pin high plus run bit.
// - timer 1 counts internal clock, or count pin falling edges when selected.
// - timer 0 counts internal clock, or count pin falling edges when selected.
// - timer 1 mode field sits in upper nibble, bits 5 and 4.
// - timer 0 mode field sits in lower nibble, bits 1 and 0.
// - mode 0 is 8-bit with 5-bit prescale; mode 1 is 16-bit.
// - mode 2 auto-reloads from high byte; mode 3 splits timer 0, stops timer 1.
module tmx_timer01 (
   // clock and reset
   input  wire logic                     core_clk,
   input  wire logic                     rst_n,
   // wishbone slave
   input  wire logic                     wb_cyc_i,
   input  wire logic                     wb_stb_i,
   input  wire logic                     wb_we_i,
   input  wire logic [`TMX_ADDR_W-1:0]   wb_adr_i,
   input  wire logic [3:0]               wb_sel_i,
   input  wire logic [31:0]              wb_dat_i,
   output logic      [31:0]              wb_dat_o,
   output logic                          wb_ack_o,
   // external pins, active low interrupt requests
   input  wire logic                     ext_irq0_pin_n,
   input  wire logic                     ext_irq1_pin_n,
   input  wire logic                     timer0_count_pin,
   input  wire logic                     timer1_count_pin,
   // interrupt controller side
   input  wire logic                     vec_timer0,
   input  wire logic                     vec_timer1,
   input  wire logic                     vec_ext0,
   input  wire logic                     vec_ext1,
   output logic                          timer0_overflow_flag,
   output logic                          timer1_overflow_flag,
   output logic                          ext_irq0_flag,
   output logic                          ext_irq1_flag
);

   logic [7:0]              tctl_r;
   logic [7:0]              tmode_r;
   tmx_pkg::tmx_count_t     cnt0_r;
   tmx_pkg::tmx_count_t     cnt1_r;
   tmx_pkg::tmx_bus_state_t bus_r;
   logic [3:0]              tick_cnt_r;
   logic [31:0]             rdata_r;

   tmx_pkg::tmx_mode_nib_t  nib0;
   tmx_pkg::tmx_mode_nib_t  nib1;
   logic                    irq0_lvl;
   logic                    irq0_fall;
   logic                    irq1_lvl;
   logic                    irq1_fall;
   logic                    cnt0_lvl;
   logic                    cnt0_fall;
   logic                    cnt1_lvl;
   logic                    cnt1_fall;
   logic                    tick;
   logic                    req;
   logic                    wr_en;
   logic                    wr_lane0;
   logic [7:0]              wbyte;
   logic                    hit_tctl;
   logic                    hit_tmode;
   logic                    hit_c0lo;
   logic                    hit_c0hi;
   logic                    hit_c1lo;
   logic                    hit_c1hi;
   logic                    hit_vec;
   logic                    inc0;
   logic                    inc1;
   logic                    inc0h;
   logic                    ovf0;
   logic                    ovf1;
   logic                    ovf0h;
   tmx_pkg::tmx_count_t     cnt0_nxt;
   tmx_pkg::tmx_count_t     cnt1_nxt;
   logic                    vec0_ack;
   logic                    vec1_ack;
   logic                    vecx0_ack;
   logic                    vecx1_ack;

   tmx_pin_sync u_sync_irq0 (
      .core_clk  (core_clk),
      .rst_n     (rst_n),
      .pin_in    (ext_irq0_pin_n),
      .pin_level (irq0_lvl),
      .pin_fall  (irq0_fall)
   );
   tmx_pin_sync u_sync_irq1 (
      .core_clk  (core_clk),
      .rst_n     (rst_n),
      .pin_in    (ext_irq1_pin_n),
      .pin_level (irq1_lvl),
      .pin_fall  (irq1_fall)
   );
   tmx_pin_sync u_sync_cnt0 (
      .core_clk  (core_clk),
      .rst_n     (rst_n),
      .pin_in    (timer0_count_pin),
      .pin_level (cnt0_lvl),
      .pin_fall  (cnt0_fall)
   );
   tmx_pin_sync u_sync_cnt1 (
      .core_clk  (core_clk),
      .rst_n     (rst_n),
      .pin_in    (timer1_count_pin),
      .pin_level (cnt1_lvl),
      .pin_fall  (cnt1_fall)
   );

   // decode of a word address against a printed byte index
   function automatic logic addr_hit(input logic [`TMX_ADDR_W-1:0] a, input logic [7:0] idx);
      addr_hit = (a == {idx, 2'b00});
   endfunction

   // timer 1 nibble in the upper half
   assign nib1 = tmx_pkg::tmx_mode_nib_t'(tmode_r[7:4]);
   // timer 0 nibble in the lower half
   assign nib0 = tmx_pkg::tmx_mode_nib_t'(tmode_r[3:0]);

   assign req       = wb_cyc_i & wb_stb_i & (bus_r == tmx_pkg::TMX_BUS_IDLE);
   assign wr_en     = req & wb_we_i;
   assign wr_lane0  = wr_en & wb_sel_i[0];
   assign wbyte     = wb_dat_i[7:0];
   assign hit_tctl  = addr_hit(wb_adr_i, `TMX_IDX_TCTL);
   assign hit_tmode = addr_hit(wb_adr_i, `TMX_IDX_TMODE);
   assign hit_c0lo  = addr_hit(wb_adr_i, `TMX_IDX_T0LO);
   assign hit_c0hi  = addr_hit(wb_adr_i, `TMX_IDX_T0HI);
   assign hit_c1lo  = addr_hit(wb_adr_i, `TMX_IDX_T1LO);
   assign hit_c1hi  = addr_hit(wb_adr_i, `TMX_IDX_T1HI);
   assign hit_vec   = addr_hit(wb_adr_i, `TMX_IDX_VEC);

   // vector acknowledges come from the port or from a software strobe register
   assign vec0_ack  = vec_timer0 | (wr_lane0 & hit_vec & wbyte[`TMX_VEC_T0]);
   assign vec1_ack  = vec_timer1 | (wr_lane0 & hit_vec & wbyte[`TMX_VEC_T1]);
   assign vecx0_ack = vec_ext0 | (wr_lane0 & hit_vec & wbyte[`TMX_VEC_X0]);
   assign vecx1_ack = vec_ext1 | (wr_lane0 & hit_vec & wbyte[`TMX_VEC_X1]);

   // machine-cycle tick for timer mode
   assign tick = (tick_cnt_r == 4'h0);

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         tick_cnt_r <= 4'h0;
      end else if (tick) begin
         tick_cnt_r <= `TMX_TICK_DIV - 4'h1;
      end else begin
         tick_cnt_r <= tick_cnt_r - 4'h1;
      end
   end

   // enables and increment sources
   always_comb begin
      logic src0;
      logic src1;
      src0 = nib0.counter_sel ? cnt0_fall : tick;
      src1 = nib1.counter_sel ? cnt1_fall : tick;
      // gate needs interrupt 0 pin high
      inc0 = src0 & tctl_r[`TMX_TC_TR0] & (~nib0.gate | irq0_lvl);
      // gate needs interrupt 1 pin high
      // timer 1 stopped in mode 3
      inc1 = src1 & tctl_r[`TMX_TC_TR1] & (~nib1.gate | irq1_lvl)
             & (nib1.mode != tmx_pkg::TMX_MODE_SPLIT);
      // split high byte of timer 0 is a timer only, run by timer 1's run bit
      inc0h = tick & tctl_r[`TMX_TC_TR1] & (nib0.mode == tmx_pkg::TMX_MODE_SPLIT);
   end

   // next count for one timer in its mode
   function automatic tmx_pkg::tmx_count_t count_step(
         input tmx_pkg::tmx_count_t c, input tmx_pkg::tmx_mode_t m, input logic inc,
         output logic ovf);
      tmx_pkg::tmx_count_t n;
      n   = c;
      ovf = 1'b0;
      if (inc) begin
         case (m)
            tmx_pkg::TMX_MODE_13BIT: begin
               if (c.low_count_byte[`TMX_PRESCALE_MSB:0] == 5'h1F) begin
                  n.low_count_byte[`TMX_PRESCALE_MSB:0] = 5'h00;
                  n.high_count_byte = c.high_count_byte + 8'h01;
                  ovf = (c.high_count_byte == 8'hFF);
               end else begin
                  n.low_count_byte[`TMX_PRESCALE_MSB:0] =
                     c.low_count_byte[`TMX_PRESCALE_MSB:0] + 5'h01;
               end
            end
            tmx_pkg::TMX_MODE_16BIT: begin
               n   = tmx_pkg::tmx_count_t'(c + 16'h0001);
               ovf = (c == 16'hFFFF);
            end
            // reload low byte from high byte
            tmx_pkg::TMX_MODE_RELOAD: begin
               ovf = (c.low_count_byte == 8'hFF);
               n.low_count_byte = ovf ? c.high_count_byte : c.low_count_byte + 8'h01;
            end
            default: begin
               n.low_count_byte = c.low_count_byte + 8'h01;
               ovf = (c.low_count_byte == 8'hFF);
            end
         endcase
      end
      return n;
   endfunction

   always_comb begin
      cnt0_nxt = count_step(cnt0_r, nib0.mode, inc0, ovf0);
      cnt1_nxt = count_step(cnt1_r, nib1.mode, inc1, ovf1);
      ovf0h    = inc0h & (cnt0_r.high_count_byte == 8'hFF);
      if (inc0h) begin
         cnt0_nxt.high_count_byte = cnt0_r.high_count_byte + 8'h01;
      end
   end

   // counters; a software write to a byte wins over counting
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cnt0_r <= 16'h0000;
         cnt1_r <= 16'h0000;
      end else begin
         cnt0_r <= cnt0_nxt;
         cnt1_r <= cnt1_nxt;
         if (wr_lane0 & hit_c0lo) begin
            cnt0_r.low_count_byte <= wbyte;
         end
         if (wr_lane0 & hit_c0hi) begin
            cnt0_r.high_count_byte <= wbyte;
         end
         if (wr_lane0 & hit_c1lo) begin
            cnt1_r.low_count_byte <= wbyte;
         end
         if (wr_lane0 & hit_c1hi) begin
            cnt1_r.high_count_byte <= wbyte;
         end
      end
   end

   // control/flag register; hardware sets win over every clear
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         tctl_r <= `TMX_TCTL_RST;
      end else begin
         if (wr_lane0 & hit_tctl) begin
            tctl_r <= wbyte;
         end
         // timer 0 flag clear on vector
         if (vec0_ack) begin
            tctl_r[`TMX_TC_TF0] <= 1'b0;
         end
         // timer 1 flag clear on vector
         if (vec1_ack) begin
            tctl_r[`TMX_TC_TF1] <= 1'b0;
         end
         // interrupt 0 edge flag clear on vector
         if (vecx0_ack & tctl_r[`TMX_TC_IT0]) begin
            tctl_r[`TMX_TC_IE0] <= 1'b0;
         end
         // interrupt 1 edge flag clear on vector
         if (vecx1_ack & tctl_r[`TMX_TC_IT1]) begin
            tctl_r[`TMX_TC_IE1] <= 1'b0;
         end
         if (ovf0) begin
            tctl_r[`TMX_TC_TF0] <= 1'b1;
         end
         // timer 1 overflow sets, also split high byte
         if (ovf1 | ovf0h) begin
            tctl_r[`TMX_TC_TF1] <= 1'b1;
         end
         if (tctl_r[`TMX_TC_IT0]) begin
            if (irq0_fall) begin
               tctl_r[`TMX_TC_IE0] <= 1'b1;
            end
         end else begin
            tctl_r[`TMX_TC_IE0] <= ~irq0_lvl;
         end
         // interrupt 1 set, level tracks pin
         if (tctl_r[`TMX_TC_IT1]) begin
            if (irq1_fall) begin
               tctl_r[`TMX_TC_IE1] <= 1'b1;
            end
         end else begin
            tctl_r[`TMX_TC_IE1] <= ~irq1_lvl;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         tmode_r <= `TMX_TMODE_RST;
      end else if (wr_lane0 & hit_tmode) begin
         tmode_r <= wbyte;
      end
   end

   // bus answer: ack one cycle after the request, then one idle cycle
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         bus_r <= tmx_pkg::TMX_BUS_IDLE;
      end else begin
         case (bus_r)
            tmx_pkg::TMX_BUS_IDLE: bus_r <= req ? tmx_pkg::TMX_BUS_ACK : tmx_pkg::TMX_BUS_IDLE;
            tmx_pkg::TMX_BUS_ACK:  bus_r <= tmx_pkg::TMX_BUS_IDLE;
            default:               bus_r <= tmx_pkg::TMX_BUS_IDLE;
         endcase
      end
   end

   // unmapped addresses read zero and writes are dropped
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rdata_r <= 32'h0000_0000;
      end else if (req & ~wb_we_i) begin
         rdata_r <= 32'h0000_0000;
         if (hit_tctl) begin
            rdata_r[7:0] <= tctl_r;
         end else if (hit_tmode) begin
            rdata_r[7:0] <= tmode_r;
         end else if (hit_c0lo) begin
            rdata_r[7:0] <= cnt0_r.low_count_byte;
         end else if (hit_c0hi) begin
            rdata_r[7:0] <= cnt0_r.high_count_byte;
         end else if (hit_c1lo) begin
            rdata_r[7:0] <= cnt1_r.low_count_byte;
         end else if (hit_c1hi) begin
            rdata_r[7:0] <= cnt1_r.high_count_byte;
         end
      end
   end

   assign wb_ack_o = (bus_r == tmx_pkg::TMX_BUS_ACK);
   assign wb_dat_o = rdata_r;

   assign timer0_overflow_flag = tctl_r[`TMX_TC_TF0];
   assign timer1_overflow_flag = tctl_r[`TMX_TC_TF1];
   assign ext_irq0_flag        = tctl_r[`TMX_TC_IE0];
   assign ext_irq1_flag        = tctl_r[`TMX_TC_IE1];

endmodule

// ---- verif/tmx_timer01_properties.sv ----
`timescale 1ns/1ps
`include "tmx_defs.svh"
module tmx_timer01_properties (
   // clock and reset
   input wire logic                   core_clk,
   input wire logic                   rst_n,
   // register bus
   input wire logic                   wb_cyc_i,
   input wire logic                   wb_stb_i,
   input wire logic                   wb_we_i,
   input wire logic [`TMX_ADDR_W-1:0] wb_adr_i,
   input wire logic [31:0]            wb_dat_o,
   input wire logic                   wb_ack_o,
   // pins and vectors
   input wire logic                   ext_irq0_pin_n,
   input wire logic                   ext_irq1_pin_n,
   input wire logic                   vec_timer0,
   input wire logic                   vec_timer1,
   input wire logic                   vec_ext0,
   input wire logic                   vec_ext1,
   // flags
   input wire logic                   timer0_overflow_flag,
   input wire logic                   timer1_overflow_flag,
   input wire logic                   ext_irq0_flag,
   input wire logic                   ext_irq1_flag
);
   wire logic req  = wb_cyc_i && wb_stb_i;
   wire logic take = req && !wb_ack_o;
   // control or vector strobe writes may change flags
   wire logic wr   = take && wb_we_i && (wb_adr_i == {`TMX_IDX_TCTL, 2'b00}
                                         || wb_adr_i == {`TMX_IDX_VEC, 2'b00});
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence s_take;
      take;
   endsequence
   sequence s_ack_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   AST_ACK_ANSWER:
   assert property (s_take |=> s_ack_pulse) else $error("request not answered by one ack");
   AST_ACK_CAUSE:
   assert property (wb_ack_o |-> $past(req)) else $error("ack without request");
   AST_DAT_UPPER:
   assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("read data upper bits");
   AST_TF0_FALL:
   assert property ($fell(timer0_overflow_flag) |-> $past(vec_timer0) || $past(wr))
      else $error("timer0 flag cleared without cause");
   AST_TF1_FALL:
   assert property ($fell(timer1_overflow_flag) |-> $past(vec_timer1) || $past(wr))
      else $error("timer1 flag cleared without cause");
   AST_IE0_RISE:
   assert property ($rose(ext_irq0_flag) |-> $past(wr) || !$past(ext_irq0_pin_n, 2)
      || !$past(ext_irq0_pin_n, 3) || !$past(ext_irq0_pin_n, 4) || !$past(ext_irq0_pin_n, 5))
      else $error("irq0 flag set without low pin");
   AST_IE1_RISE:
   assert property ($rose(ext_irq1_flag) |-> $past(wr) || !$past(ext_irq1_pin_n, 2)
      || !$past(ext_irq1_pin_n, 3) || !$past(ext_irq1_pin_n, 4) || !$past(ext_irq1_pin_n, 5))
      else $error("irq1 flag set without low pin");
   AST_IE0_FALL:
   assert property ($fell(ext_irq0_flag) |-> $past(vec_ext0) || $past(wr)
      || $past(ext_irq0_pin_n, 2) || $past(ext_irq0_pin_n, 3) || $past(ext_irq0_pin_n, 4))
      else $error("irq0 flag cleared without cause");
   AST_IE1_FALL:
   assert property ($fell(ext_irq1_flag) |-> $past(vec_ext1) || $past(wr)
      || $past(ext_irq1_pin_n, 2) || $past(ext_irq1_pin_n, 3) || $past(ext_irq1_pin_n, 4))
      else $error("irq1 flag cleared without cause");
endmodule

bind tmx_timer01 tmx_timer01_properties u_props (.core_clk(core_clk), .rst_n(rst_n),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_irq0_pin_n(ext_irq0_pin_n),
   .ext_irq1_pin_n(ext_irq1_pin_n), .vec_timer0(vec_timer0), .vec_timer1(vec_timer1),
   .vec_ext0(vec_ext0), .vec_ext1(vec_ext1), .timer0_overflow_flag(timer0_overflow_flag),
   .timer1_overflow_flag(timer1_overflow_flag), .ext_irq0_flag(ext_irq0_flag),
   .ext_irq1_flag(ext_irq1_flag));

// ---- verif/tmx_pin_model.sv ----
`timescale 1ns/1ps
module tmx_pin_model (
   // clock
   input  wire logic core_clk,
   // pins toward the block, idle high like pulled-up lines
   output logic      ext_irq0_pin_n,
   output logic      ext_irq1_pin_n,
   output logic      timer0_count_pin,
   output logic      timer1_count_pin
);
   initial begin
      ext_irq0_pin_n = 1'b1;
      ext_irq1_pin_n = 1'b1;
      timer0_count_pin = 1'b1;
      timer1_count_pin = 1'b1;
   end
   task automatic set_irq(input int k, input logic v);
      @(posedge core_clk);
      if (k == 0) ext_irq0_pin_n <= v;
      else ext_irq1_pin_n <= v;
   endtask
   // w sets how slowly edges come; below one clock the synchroniser may miss them
   task automatic pulse_count(input int k, input int n, input int w);
      repeat (n) begin
         @(posedge core_clk);
         if (k == 0) timer0_count_pin <= 1'b0;
         else timer1_count_pin <= 1'b0;
         repeat (w) @(posedge core_clk);
         if (k == 0) timer0_count_pin <= 1'b1;
         else timer1_count_pin <= 1'b1;
         repeat (w) @(posedge core_clk);
      end
   endtask
endmodule

// ---- verif/tmx_timer01_tb.sv ----
`timescale 1ns/1ps
module tmx_timer01_tb;
   logic        core_clk, rst_n, cyc, stb, we, gate;
   logic [9:0]  adr;
   logic [3:0]  sel, vec;
   logic [31:0] dat_w, q;
   logic [1:0]  m;
   logic [7:0]  h, l, d, run;
   logic [16:0] e;
   wire  [31:0] dat_r;
   wire  [3:0]  flags;
   wire         ack, irq0_n, irq1_n, cnt0, cnt1;
   int          err_count, num_checks, seed, cycles, i, tmr, n;

   always #50 core_clk = ~core_clk;

   tmx_timer01 dut (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
      .wb_ack_o(ack), .ext_irq0_pin_n(irq0_n), .ext_irq1_pin_n(irq1_n),
      .timer0_count_pin(cnt0), .timer1_count_pin(cnt1), .vec_timer0(vec[0]),
      .vec_timer1(vec[1]), .vec_ext0(vec[2]), .vec_ext1(vec[3]),
      .timer0_overflow_flag(flags[0]), .timer1_overflow_flag(flags[1]),
      .ext_irq0_flag(flags[2]), .ext_irq1_flag(flags[3]));
   tmx_pin_model pins (.core_clk(core_clk), .ext_irq0_pin_n(irq0_n), .ext_irq1_pin_n(irq1_n),
      .timer0_count_pin(cnt0), .timer1_count_pin(cnt1));

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_rng(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
      num_checks++;
      if (!((got >= lo) === 1'b1 && (got <= hi) === 1'b1)) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask
   task automatic bus(input logic [9:0] a, input logic w, input logic [7:0] dv);
      @(posedge core_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hF;
      dat_w <= {24'h0, dv};
      // no local limit: only the cycle ceiling may end a wait for ack
      do begin
         @(posedge core_clk);
      end while (ack !== 1'b1);
      q = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic pulse_vec(input int k);
      @(posedge core_clk);
      vec[k] <= 1'b1;
      @(posedge core_clk);
      vec[k] <= 1'b0;
   endtask
   // count bytes and overflow after n count-pin edges
   function automatic logic [16:0] advance(input int t, input logic [1:0] md,
                                           input logic [7:0] hb, input logic [7:0] lb,
                                           input int cnt);
      logic ov;
      ov = 1'b0;
      repeat (cnt) begin
         case (md)
            2'h0: begin
               if (lb[4:0] == 5'h1F) begin
                  ov |= (hb == 8'hFF);
                  hb++;
               end
               lb[4:0] = lb[4:0] + 5'h01;
            end
            2'h1: begin
               ov |= ({hb, lb} == 16'hFFFF);
               {hb, lb} = {hb, lb} + 16'h0001;
            end
            2'h2: begin
               ov |= (lb == 8'hFF);
               lb = (lb == 8'hFF) ? hb : lb + 8'h01;
            end
            default: if (t == 0) begin
               ov |= (lb == 8'hFF);
               lb++;
            end
         endcase
      end
      return {ov, hb, lb};
   endfunction

   always @(posedge core_clk) begin
      cycles++;
      if (cycles > 30000) begin
         err_count++;
         end_of_test();
      end
   end

   initial begin
      core_clk = 1'b0;
      rst_n = 1'b0;
      {cyc, stb, we, adr, sel, dat_w, vec} = '0;
      {err_count, num_checks, cycles} = '0;
      seed = 54;
      repeat (12) @(posedge core_clk);
      rst_n <= 1'b1;
      bus(10'h220, 1'b0, 8'h00);
      chk(q, 32'h0);
      bus(10'h224, 1'b0, 8'h00);
      chk(q, 32'h0);
      bus(10'h3FC, 1'b1, 8'hFF);
      bus(10'h3FC, 1'b0, 8'h00);
      chk(q, 32'h0);
      repeat (4) begin
         d = 8'($random(seed));
         bus(10'h224, 1'b1, d);
         bus(10'h224, 1'b0, 8'h00);
         chk(q, {24'h0, d});
      end
      bus(10'h220, 1'b1, 8'hA0);
      bus(10'h220, 1'b0, 8'h00);
      chk(q, 32'hA0);
      chk(32'(flags[1:0]), 32'h3);
      pulse_vec(0);
      bus(10'h220, 1'b0, 8'h00);
      chk(q, 32'h80);
      pulse_vec(1);
      bus(10'h220, 1'b0, 8'h00);
      chk(q, 32'h00);
      bus(10'h220, 1'b1, 8'hA0);
      bus(10'h310, 1'b1, 8'h03);
      bus(10'h220, 1'b0, 8'h00);
      chk(q, 32'h00);
      $display("test registers done");
      for (i = 0; i < 16; i++) begin
         tmr = i % 2;
         m = 2'($random(seed));
         gate = 1'($random(seed));
         h = 8'($random(seed));
         l = 8'($random(seed));
         n = 1 + ($random(seed) & 3);
         run = tmr ? 8'h40 : 8'h10;
         bus(10'h220, 1'b1, 8'h00);
         bus(10'h224, 1'b1, 8'({gate, 1'b1, m}) << (4 * tmr));
         bus(tmr ? 10'h308 : 10'h300, 1'b1, l);
         bus(tmr ? 10'h30C : 10'h304, 1'b1, h);
         // edges while gated or stopped must not count
         if (gate) begin
            bus(10'h220, 1'b1, run);
            pins.set_irq(tmr, 1'b0);
            pins.pulse_count(tmr, 2, 3);
            pins.set_irq(tmr, 1'b1);
         end else begin
            pins.pulse_count(tmr, 2, 3);
            bus(10'h220, 1'b1, run);
         end
         pins.pulse_count(tmr, n, 2 + i % 3);
         repeat (8) @(posedge core_clk);
         e = advance(tmr, m, h, l, n);
         bus(10'h220, 1'b0, 8'h00);
         chk(q, {24'h0, run | (e[16] ? (tmr ? 8'h80 : 8'h20) : 8'h00)});
         bus(tmr ? 10'h308 : 10'h300, 1'b0, 8'h00);
         chk(q, {24'h0, e[7:0]});
         bus(tmr ? 10'h30C : 10'h304, 1'b0, 8'h00);
         chk(q, {24'h0, e[15:8]});
      end
      $display("test counter modes done");
      for (i = 0; i < 2; i++) begin
         bus(10'h224, 1'b1, i ? 8'h10 : 8'h01);
         bus(i ? 10'h308 : 10'h300, 1'b1, 8'h00);
         bus(10'h220, 1'b1, i ? 8'h40 : 8'h10);
         repeat (120) @(posedge core_clk);
         bus(10'h220, 1'b1, 8'h00);
         bus(i ? 10'h308 : 10'h300, 1'b0, 8'h00);
         chk_rng(q[7:0], 8'h09, 8'h0B);
      end
      $display("test internal clock done");
      // split timer 0: high byte ticks under timer 1's run bit and sets timer 1's flag
      bus(10'h224, 1'b1, 8'h33);
      bus(10'h304, 1'b1, 8'hFF);
      bus(10'h220, 1'b1, 8'h40);
      repeat (30) @(posedge core_clk);
      bus(10'h220, 1'b0, 8'h00);
      chk(q, 32'hC0);
      chk(32'(flags[1]), 32'h1);
      bus(10'h304, 1'b0, 8'h00);
      chk_rng(q[7:0], 8'h01, 8'h03);
      $display("test split mode done");
      for (i = 0; i < 2; i++) begin
         bus(10'h220, 1'b1, i ? 8'h04 : 8'h01);
         pins.set_irq(i, 1'b0);
         repeat (8) @(posedge core_clk);
         chk(32'(flags[2 + i]), 32'h1);
         pins.set_irq(i, 1'b1);
         repeat (8) @(posedge core_clk);
         chk(32'(flags[2 + i]), 32'h1);
         pulse_vec(2 + i);
         @(posedge core_clk);
         chk(32'(flags[2 + i]), 32'h0);
         bus(10'h220, 1'b1, 8'h00);
         pins.set_irq(i, 1'b0);
         repeat (8) @(posedge core_clk);
         chk(32'(flags[2 + i]), 32'h1);
         pulse_vec(2 + i);
         @(posedge core_clk);
         chk(32'(flags[2 + i]), 32'h1);
         pins.set_irq(i, 1'b1);
         repeat (8) @(posedge core_clk);
         chk(32'(flags[2 + i]), 32'h0);
      end
      $display("test external interrupts done");
      end_of_test();
   end
endmodule
